// >>> logic/core_regs_pkg.sv
// constants, types and field layout shared by the core register block and its memory
package core_regs_pkg;

  // data path widths
  localparam int DATA_W = 8;
  localparam int FILE_W = 7;
  localparam int ADDR_W = 9;
  localparam int BANK_W = 2;

  // general-purpose storage: 64 x 8, bank 0 only, low offsets 20h..5Fh
  localparam int GPR_DEPTH = 64;
  localparam int GPR_AW = 6;
  localparam logic [FILE_W-1:0] GPR_FIRST = 7'h20;
  localparam logic [FILE_W-1:0] GPR_LAST = 7'h5F;
  localparam logic [BANK_W-1:0] GPR_BANK = 2'h0;

  // core register offsets, mirrored at the same low offset in every bank
  localparam logic [FILE_W-1:0] OFS_INDIRECT_DATA_PORT = 7'h00;
  localparam logic [FILE_W-1:0] OFS_PROG_COUNTER_LOW = 7'h02;
  localparam logic [FILE_W-1:0] OFS_CORE_STATUS = 7'h03;
  localparam logic [FILE_W-1:0] OFS_INDIRECT_POINTER = 7'h04;
  localparam logic [FILE_W-1:0] OFS_PROG_COUNTER_HIGH_LATCH = 7'h0A;
  localparam logic [FILE_W-1:0] OFS_IRQ_CONTROL = 7'h0B;

  // status bit positions
  localparam int ST_INDIRECT_BANK = 7;
  localparam int ST_BANK_HI = 6;
  localparam int ST_BANK_LO = 5;
  localparam int ST_WATCHDOG_N = 4;
  localparam int ST_SLEEP_N = 3;
  localparam int ST_ZERO = 2;
  localparam int ST_NIB = 1;
  localparam int ST_CARRY = 0;
  localparam int NIB_BIT = 4;
  localparam int FLAG_W = 3;

  // reset values: bank selects zero, expiry and sleep markers one, flags zero
  localparam logic [DATA_W-1:0] CORE_STATUS_RST = 8'h18;
  localparam logic [DATA_W-1:0] CORE_REG_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // which of zero / nibble / carry each kind of operation owns
  localparam logic [FLAG_W-1:0] FMASK_NONE = 3'h0;
  localparam logic [FLAG_W-1:0] FMASK_ZERO = 3'h4;
  localparam logic [FLAG_W-1:0] FMASK_ARITH = 3'h7;
  localparam logic [FLAG_W-1:0] FMASK_CARRY = 3'h1;

  // flag-affecting operation the core is executing this cycle
  typedef enum logic [2:0] {
    ALU_NONE,
    ALU_LOGIC,
    ALU_CLEAR,
    ALU_ADD,
    ALU_SUB,
    ALU_ROT_LEFT,
    ALU_ROT_RIGHT
  } alu_op_e;

  // what a resolved data address lands on
  typedef enum logic [1:0] {
    CLS_NONE,
    CLS_CORE,
    CLS_GPR
  } addr_class_e;

endpackage

// >>> logic/gpr_store.sv
// 64 x 8 general-purpose storage with registered read data
`timescale 1ns/10ps
module gpr_store (
  // clock, reset, freeze
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // write side
  input wire logic wr_en,
  input wire logic [core_regs_pkg::GPR_AW-1:0] wr_idx,
  input wire logic [core_regs_pkg::DATA_W-1:0] wr_data,
  // read side
  input wire logic rd_en,
  input wire logic [core_regs_pkg::GPR_AW-1:0] rd_idx,
  output logic [core_regs_pkg::DATA_W-1:0] rd_q
);

  // storage array, no reset: contents are undefined after power-up
  logic [core_regs_pkg::DATA_W-1:0] mem_q [core_regs_pkg::GPR_DEPTH];

  // write port
  always_ff @(posedge clk) begin
    if (clk_en && wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // read port, registered; a same-cycle write is not seen (old data returned)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_q <= core_regs_pkg::DATA_ZERO;
    end else if (clk_en && rd_en) begin
      rd_q <= mem_q[rd_idx];
    end
  end

endmodule

// >>> logic/core_status_register_banking.sv
// core register file, banked status register and flag logic of the 8-bit core
`timescale 1ns/10ps
module core_status_register_banking (
  // clock, reset, freeze
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // data memory access from the core
  input wire logic [core_regs_pkg::FILE_W-1:0] FILE_ADDR,
  input wire logic RD_EN,
  input wire logic WR_EN,
  input wire logic [core_regs_pkg::DATA_W-1:0] WR_DATA,
  output logic [core_regs_pkg::DATA_W-1:0] RD_DATA,
  output logic RD_VALID,
  // flag-affecting operation of the current instruction
  input wire core_regs_pkg::alu_op_e ALU_OP,
  input wire logic [core_regs_pkg::DATA_W-1:0] ALU_A,
  input wire logic [core_regs_pkg::DATA_W-1:0] ALU_B,
  output logic [core_regs_pkg::DATA_W-1:0] ALU_RESULT,
  // reset-cause events from the watchdog and sleep logic
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic WATCHDOG_KICK_INSTR,
  input wire logic SLEEP_INSTR,
  // core register contents
  output logic [core_regs_pkg::DATA_W-1:0] CORE_STATUS,
  output logic [core_regs_pkg::DATA_W-1:0] INDIRECT_POINTER,
  output logic [core_regs_pkg::DATA_W-1:0] PROG_COUNTER_LOW,
  output logic [core_regs_pkg::DATA_W-1:0] PROG_COUNTER_HIGH_LATCH,
  output logic [core_regs_pkg::DATA_W-1:0] IRQ_CONTROL
);

  ////////////////////////////////////////////////////////////////////////////
  // address decoding helpers

  // classify a resolved 9-bit data address
  function automatic core_regs_pkg::addr_class_e addr_class(
    input logic [core_regs_pkg::ADDR_W-1:0] a
  );
    logic [core_regs_pkg::FILE_W-1:0] lo;
    logic [core_regs_pkg::BANK_W-1:0] bank;
    lo = a[core_regs_pkg::FILE_W-1:0];
    bank = a[core_regs_pkg::ADDR_W-1:core_regs_pkg::FILE_W];
    // core registers ignore the bank bits so every mirror hits one register
    if (lo == core_regs_pkg::OFS_PROG_COUNTER_LOW || lo == core_regs_pkg::OFS_CORE_STATUS ||
        lo == core_regs_pkg::OFS_INDIRECT_POINTER ||
        lo == core_regs_pkg::OFS_PROG_COUNTER_HIGH_LATCH ||
        lo == core_regs_pkg::OFS_IRQ_CONTROL) begin
      addr_class = core_regs_pkg::CLS_CORE;
    end else if (bank == core_regs_pkg::GPR_BANK && lo >= core_regs_pkg::GPR_FIRST &&
                 lo <= core_regs_pkg::GPR_LAST) begin
      addr_class = core_regs_pkg::CLS_GPR;
    end else begin
      // includes the indirect port reached through itself
      addr_class = core_regs_pkg::CLS_NONE;
    end
  endfunction

  // which flags an operation owns
  function automatic logic [core_regs_pkg::FLAG_W-1:0] flag_mask(
    input core_regs_pkg::alu_op_e op
  );
    unique case (op)
      core_regs_pkg::ALU_NONE: flag_mask = core_regs_pkg::FMASK_NONE;
      core_regs_pkg::ALU_LOGIC: flag_mask = core_regs_pkg::FMASK_ZERO;
      core_regs_pkg::ALU_CLEAR: flag_mask = core_regs_pkg::FMASK_ZERO;
      core_regs_pkg::ALU_ADD: flag_mask = core_regs_pkg::FMASK_ARITH;
      core_regs_pkg::ALU_SUB: flag_mask = core_regs_pkg::FMASK_ARITH;
      core_regs_pkg::ALU_ROT_LEFT: flag_mask = core_regs_pkg::FMASK_CARRY;
      core_regs_pkg::ALU_ROT_RIGHT: flag_mask = core_regs_pkg::FMASK_CARRY;
      default: flag_mask = core_regs_pkg::FMASK_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and signals

  logic [core_regs_pkg::DATA_W-1:0] status_q, status_d;  // banked status
  logic [core_regs_pkg::DATA_W-1:0] ind_ptr_q;  // indirect pointer
  logic [core_regs_pkg::DATA_W-1:0] pcl_q;  // program counter low byte
  logic [core_regs_pkg::DATA_W-1:0] pch_latch_q;  // program counter high latch
  logic [core_regs_pkg::DATA_W-1:0] irq_ctl_q;  // interrupt control
  logic [core_regs_pkg::ADDR_W-1:0] eff_addr;  // resolved data address
  core_regs_pkg::addr_class_e eff_class;  // what the address lands on
  logic [core_regs_pkg::GPR_AW-1:0] gpr_idx;  // storage index
  logic [core_regs_pkg::DATA_W-1:0] core_rd;  // core register read value
  logic [core_regs_pkg::DATA_W-1:0] gpr_rd_q;  // storage read data
  core_regs_pkg::addr_class_e rd_class_q;  // class of pending read
  logic [core_regs_pkg::DATA_W-1:0] core_rd_q;  // captured core value
  logic rd_pend_q;  // read in flight
  logic wr_status;  // data write aimed at status
  // alu
  logic [core_regs_pkg::DATA_W-1:0] opnd_b;  // second operand, inverted for sub
  logic carry_in;  // one for two's complement subtract
  logic [core_regs_pkg::DATA_W:0] sum9;  // full sum with carry out
  logic [core_regs_pkg::NIB_BIT:0] nib5;  // low nibble sum with carry out
  logic [core_regs_pkg::DATA_W-1:0] alu_res;  // operation result
  logic [core_regs_pkg::FLAG_W-1:0] new_flags;  // zero, nibble, carry
  logic [core_regs_pkg::FLAG_W-1:0] fmask;  // flags owned by this op

  ////////////////////////////////////////////////////////////////////////////
  // address resolution

  // indirect port swaps in pointer + indirect bank bit; else direct bank + offset
  always_comb begin
    if (FILE_ADDR == core_regs_pkg::OFS_INDIRECT_DATA_PORT) begin
      eff_addr = {status_q[core_regs_pkg::ST_INDIRECT_BANK], ind_ptr_q};
    end else begin
      eff_addr = {status_q[core_regs_pkg::ST_BANK_HI:core_regs_pkg::ST_BANK_LO],
                  FILE_ADDR};
    end
  end

  assign eff_class = addr_class(eff_addr);
  assign gpr_idx = core_regs_pkg::GPR_AW'(eff_addr[core_regs_pkg::FILE_W-1:0] -
                                          core_regs_pkg::GPR_FIRST);
  assign wr_status = WR_EN && eff_class == core_regs_pkg::CLS_CORE &&
                     eff_addr[core_regs_pkg::FILE_W-1:0] == core_regs_pkg::OFS_CORE_STATUS;

  // core register read mux
  always_comb begin
    unique case (eff_addr[core_regs_pkg::FILE_W-1:0])
      core_regs_pkg::OFS_PROG_COUNTER_LOW: core_rd = pcl_q;
      core_regs_pkg::OFS_CORE_STATUS: core_rd = status_q;
      core_regs_pkg::OFS_INDIRECT_POINTER: core_rd = ind_ptr_q;
      core_regs_pkg::OFS_PROG_COUNTER_HIGH_LATCH: core_rd = pch_latch_q;
      core_regs_pkg::OFS_IRQ_CONTROL: core_rd = irq_ctl_q;
      default: core_rd = core_regs_pkg::DATA_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage

  gpr_store u_gpr (
    .clk(CLK),
    .rst(SYS_RST),
    .clk_en(CLK_EN),
    .wr_en(WR_EN && eff_class == core_regs_pkg::CLS_GPR),
    .wr_idx(gpr_idx),
    .wr_data(WR_DATA),
    .rd_en(RD_EN && eff_class == core_regs_pkg::CLS_GPR),
    .rd_idx(gpr_idx),
    .rd_q(gpr_rd_q)
  );

  // read pipeline stage 1: remember class and core value at request time
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_pend_q <= 1'b0;
      rd_class_q <= core_regs_pkg::CLS_NONE;
      core_rd_q <= core_regs_pkg::DATA_ZERO;
    end else if (CLK_EN) begin
      rd_pend_q <= RD_EN;
      rd_class_q <= eff_class;
      core_rd_q <= core_rd;
    end
  end

  // read pipeline stage 2: output straight from a flop, two edges after request
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RD_VALID <= 1'b0;
      RD_DATA <= core_regs_pkg::DATA_ZERO;
    end else if (CLK_EN) begin
      RD_VALID <= rd_pend_q;
      if (rd_pend_q) begin
        unique case (rd_class_q)
          core_regs_pkg::CLS_CORE: RD_DATA <= core_rd_q;
          core_regs_pkg::CLS_GPR: RD_DATA <= gpr_rd_q;
          core_regs_pkg::CLS_NONE: RD_DATA <= core_regs_pkg::DATA_ZERO;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain core registers: hold whatever the core writes

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ind_ptr_q <= core_regs_pkg::CORE_REG_RST;
      pcl_q <= core_regs_pkg::CORE_REG_RST;
      pch_latch_q <= core_regs_pkg::CORE_REG_RST;
      irq_ctl_q <= core_regs_pkg::CORE_REG_RST;
    end else if (CLK_EN && WR_EN && eff_class == core_regs_pkg::CLS_CORE) begin
      // one physical register behind every bank mirror
      unique case (eff_addr[core_regs_pkg::FILE_W-1:0])
        core_regs_pkg::OFS_INDIRECT_POINTER: ind_ptr_q <= WR_DATA;
        core_regs_pkg::OFS_PROG_COUNTER_LOW: pcl_q <= WR_DATA;
        core_regs_pkg::OFS_PROG_COUNTER_HIGH_LATCH: pch_latch_q <= WR_DATA;
        core_regs_pkg::OFS_IRQ_CONTROL: irq_ctl_q <= WR_DATA;
        default: ;  // status has its own process
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag generation

  // subtract is an add of the inverted operand with carry in of one
  always_comb begin
    carry_in = (ALU_OP == core_regs_pkg::ALU_SUB);
    opnd_b = carry_in ? ~ALU_B : ALU_B;
    sum9 = {1'b0, ALU_A} + {1'b0, opnd_b} + {{core_regs_pkg::DATA_W{1'b0}}, carry_in};
    nib5 = {1'b0, ALU_A[core_regs_pkg::NIB_BIT-1:0]} +
           {1'b0, opnd_b[core_regs_pkg::NIB_BIT-1:0]} +
           {{core_regs_pkg::NIB_BIT{1'b0}}, carry_in};
    fmask = flag_mask(ALU_OP);
    unique case (ALU_OP)
      core_regs_pkg::ALU_CLEAR: alu_res = core_regs_pkg::DATA_ZERO;
      core_regs_pkg::ALU_ADD, core_regs_pkg::ALU_SUB: alu_res = sum9[core_regs_pkg::DATA_W-1:0];
      core_regs_pkg::ALU_ROT_LEFT:
        alu_res = {ALU_A[core_regs_pkg::DATA_W-2:0], status_q[core_regs_pkg::ST_CARRY]};
      core_regs_pkg::ALU_ROT_RIGHT:
        alu_res = {status_q[core_regs_pkg::ST_CARRY], ALU_A[core_regs_pkg::DATA_W-1:1]};
      default: alu_res = ALU_A;  // logic result is handed in on operand a
    endcase
    new_flags[core_regs_pkg::ST_ZERO] = (alu_res == core_regs_pkg::DATA_ZERO);
    new_flags[core_regs_pkg::ST_NIB] = nib5[core_regs_pkg::NIB_BIT];
    // rotates take the bit that falls off the end
    if (ALU_OP == core_regs_pkg::ALU_ROT_LEFT) begin
      new_flags[core_regs_pkg::ST_CARRY] = ALU_A[core_regs_pkg::DATA_W-1];
    end else if (ALU_OP == core_regs_pkg::ALU_ROT_RIGHT) begin
      new_flags[core_regs_pkg::ST_CARRY] = ALU_A[0];
    end else begin
      new_flags[core_regs_pkg::ST_CARRY] = sum9[core_regs_pkg::DATA_W];
    end
  end

  // result goes back to the core one edge later
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ALU_RESULT <= core_regs_pkg::DATA_ZERO;
    end else if (CLK_EN) begin
      ALU_RESULT <= alu_res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register

  // software write first, then flag override, then hardware events on top
  always_comb begin
    status_d = status_q;
    if (wr_status) begin
      status_d[core_regs_pkg::ST_INDIRECT_BANK:core_regs_pkg::ST_BANK_LO] =
        WR_DATA[core_regs_pkg::ST_INDIRECT_BANK:core_regs_pkg::ST_BANK_LO];
      // expiry and sleep bits are not software writable; a clear keeps nibble and carry
      if (ALU_OP != core_regs_pkg::ALU_CLEAR) begin
        status_d[core_regs_pkg::ST_ZERO:0] = WR_DATA[core_regs_pkg::ST_ZERO:0];
      end else begin
        status_d[core_regs_pkg::ST_ZERO:0] = status_q[core_regs_pkg::ST_ZERO:0];
      end
    end
    // an op that owns a flag wins over the data write to it
    status_d[core_regs_pkg::ST_ZERO:0] = (status_d[core_regs_pkg::ST_ZERO:0] & ~fmask) |
                                         (new_flags & fmask);
    // kick and sleep restart the markers; an expiry in the same cycle still wins
    if (WATCHDOG_KICK_INSTR) begin
      status_d[core_regs_pkg::ST_WATCHDOG_N] = 1'b1;
      status_d[core_regs_pkg::ST_SLEEP_N] = 1'b1;
    end else if (SLEEP_INSTR) begin
      status_d[core_regs_pkg::ST_WATCHDOG_N] = 1'b1;
      status_d[core_regs_pkg::ST_SLEEP_N] = 1'b0;
    end
    if (WATCHDOG_TIMEOUT) begin
      status_d[core_regs_pkg::ST_WATCHDOG_N] = 1'b0;
    end
  end

  // flags come up zero rather than unknown so simulation stays clean
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      status_q <= core_regs_pkg::CORE_STATUS_RST;
    end else if (CLK_EN) begin
      status_q <= status_d;
    end
  end

  // outputs mirror the register flops directly
  assign CORE_STATUS = status_q;
  assign INDIRECT_POINTER = ind_ptr_q;
  assign PROG_COUNTER_LOW = pcl_q;
  assign PROG_COUNTER_HIGH_LATCH = pch_latch_q;
  assign IRQ_CONTROL = irq_ctl_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // helpers computed independently of the adder above
  logic chk_add_c, chk_add_nib, chk_sub_nb, chk_a_zero, chk_unmapped, chk_quiet_evt;
  assign chk_add_c = ({1'b0, ALU_A} + {1'b0, ALU_B}) > {1'b0, 8'hFF};
  assign chk_add_nib = ({1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]}) > 5'h0F;
  assign chk_sub_nb = (ALU_A >= ALU_B);
  assign chk_a_zero = (ALU_A == 8'h00);
  assign chk_unmapped = RD_EN && (eff_class == core_regs_pkg::CLS_NONE);
  assign chk_quiet_evt = !WATCHDOG_TIMEOUT && !WATCHDOG_KICK_INSTR && !SLEEP_INSTR;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_clear_status;
    CLK_EN && wr_status && ALU_OP == core_regs_pkg::ALU_CLEAR && chk_quiet_evt;
  endsequence
  sequence s_unmapped_read;
    CLK_EN && chk_unmapped ##1 CLK_EN;
  endsequence

  property p_add_carry;
    CLK_EN && ALU_OP == core_regs_pkg::ALU_ADD |=> CORE_STATUS[0] == $past(chk_add_c);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

  property p_add_nib;
    CLK_EN && ALU_OP == core_regs_pkg::ALU_ADD |=> CORE_STATUS[1] == $past(chk_add_nib);
  endproperty
  a_add_nib: assert property (p_add_nib) else $error("nibble carry wrong");

  property p_sub_borrow;
    CLK_EN && ALU_OP == core_regs_pkg::ALU_SUB |=> CORE_STATUS[0] == $past(chk_sub_nb);
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");

  property p_logic_zero;
    CLK_EN && ALU_OP == core_regs_pkg::ALU_LOGIC |=> CORE_STATUS[2] == $past(chk_a_zero);
  endproperty
  a_logic_zero: assert property (p_logic_zero) else $error("zero flag wrong");

  property p_rot_left;
    CLK_EN && ALU_OP == core_regs_pkg::ALU_ROT_LEFT |=> CORE_STATUS[0] == $past(ALU_A[7]);
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate carry wrong");

  property p_clear_status;
    s_clear_status |=> CORE_STATUS[7:5] == 3'b000 && CORE_STATUS[2] &&
                       CORE_STATUS[1:0] == $past(CORE_STATUS[1:0]) &&
                       CORE_STATUS[4:3] == $past(CORE_STATUS[4:3]);
  endproperty
  a_clear_status: assert property (p_clear_status) else $error("clear of status wrong");

  property p_sw_markers;
    CLK_EN && wr_status && chk_quiet_evt |=> $stable(CORE_STATUS[4:3]);
  endproperty
  a_sw_markers: assert property (p_sw_markers) else $error("marker bits written");

  property p_timeout;
    CLK_EN && WATCHDOG_TIMEOUT |=> !CORE_STATUS[4] ##1 (CLK_EN || !CORE_STATUS[4]);
  endproperty
  a_timeout: assert property (p_timeout) else $error("expiry not recorded");

  property p_sleep;
    CLK_EN && SLEEP_INSTR && !WATCHDOG_KICK_INSTR && !WATCHDOG_TIMEOUT
      |=> CORE_STATUS[4:3] == 2'b10;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep markers wrong");

  property p_unmapped_zero;
    s_unmapped_read |=> RD_VALID && RD_DATA == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

endmodule

// >>> bench/core_model.sv
// behavioural model of the core's request side facing the register block
`timescale 1ns/10ps
module core_model (
  // clock
  input wire logic clk,
  // requests towards the register block
  output logic clk_en,
  output logic [core_regs_pkg::FILE_W-1:0] file_addr,
  output logic rd_en,
  output logic wr_en,
  output logic [core_regs_pkg::DATA_W-1:0] wr_data,
  // operation of the current instruction
  output core_regs_pkg::alu_op_e alu_op,
  output logic [core_regs_pkg::DATA_W-1:0] alu_a,
  output logic [core_regs_pkg::DATA_W-1:0] alu_b,
  // reset-cause events {timeout, kick, sleep}
  output logic [2:0] events
);
  ////////////////////////////////////////////////////////////////////////////
  // idle values from time zero so nothing floats before the first request
  initial begin
    clk_en = 1'b1;
    file_addr = 7'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wr_data = 8'h00;
    alu_op = core_regs_pkg::ALU_NONE;
    alu_a = 8'h00;
    alu_b = 8'h00;
    events = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one instruction cycle, then idle; status can be altered by moves, flag operations and events
  task req(input logic r, input logic w, input logic [6:0] a, input logic [7:0] d,
    input core_regs_pkg::alu_op_e op, input logic [7:0] x, input logic [7:0] y,
    input logic [2:0] e, input logic en);
    @(posedge clk);
    clk_en <= en;
    rd_en <= r;
    wr_en <= w;
    file_addr <= a;
    wr_data <= d;
    alu_op <= op;
    alu_a <= x;
    alu_b <= y;
    events <= e;
    @(posedge clk);
    // release enables, operation and events so the next edge sees an idle core
    clk_en <= 1'b1;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    alu_op <= core_regs_pkg::ALU_NONE;
    events <= 3'h0;
    #1;
  endtask
endmodule

// >>> bench/core_status_register_banking_test.sv
// self-checking bench for the banked core register block
`timescale 1ns/10ps
module core_status_register_banking_test;
  logic CLK;
  logic SYS_RST;
  logic CLK_EN, RD_EN, WR_EN, RD_VALID;
  logic [6:0] FILE_ADDR;
  logic [7:0] WR_DATA, RD_DATA, ALU_A, ALU_B, ALU_RESULT, CORE_STATUS;
  logic [7:0] INDIRECT_POINTER, PROG_COUNTER_LOW, PROG_COUNTER_HIGH_LATCH, IRQ_CONTROL;
  core_regs_pkg::alu_op_e ALU_OP;
  logic [2:0] ev_w; // {timeout, kick, sleep}
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed;
  logic [7:0] exp_q[$]; // expected read data, oldest first
  logic [7:0] st, g; // expected status, stored byte

  core_model i_core (.clk(CLK), .clk_en(CLK_EN), .file_addr(FILE_ADDR), .rd_en(RD_EN),
    .wr_en(WR_EN), .wr_data(WR_DATA), .alu_op(ALU_OP), .alu_a(ALU_A), .alu_b(ALU_B),
    .events(ev_w));
  core_status_register_banking i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
    .FILE_ADDR(FILE_ADDR), .RD_EN(RD_EN), .WR_EN(WR_EN), .WR_DATA(WR_DATA),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .ALU_OP(ALU_OP), .ALU_A(ALU_A), .ALU_B(ALU_B),
    .ALU_RESULT(ALU_RESULT), .WATCHDOG_TIMEOUT(ev_w[2]), .WATCHDOG_KICK_INSTR(ev_w[1]),
    .SLEEP_INSTR(ev_w[0]), .CORE_STATUS(CORE_STATUS), .INDIRECT_POINTER(INDIRECT_POINTER),
    .PROG_COUNTER_LOW(PROG_COUNTER_LOW), .PROG_COUNTER_HIGH_LATCH(PROG_COUNTER_HIGH_LATCH),
    .IRQ_CONTROL(IRQ_CONTROL));

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task print_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // hang guard: the whole run needs under a hundred cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("[FAIL] %0t run did not finish", $time);
      print_verdict();
    end
  end

  // read watcher: each valid read answers the oldest note
  always @(posedge CLK) begin
    if (RD_VALID === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[FAIL] %0t read data without a request", $time);
      end else check(RD_DATA, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access helpers; a read only notes its expectation, the watcher compares
  task wr(input logic [6:0] a, input logic [7:0] d);
    i_core.req(1'b0, 1'b1, a, d, core_regs_pkg::ALU_NONE, 8'h00, 8'h00, 3'h0, 1'b1);
  endtask

  task rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_core.req(1'b1, 1'b0, a, 8'h00, core_regs_pkg::ALU_NONE, 8'h00, 8'h00, 3'h0, 1'b1);
  endtask

  task ev(input logic [2:0] e, input logic en, input logic [1:0] x);
    i_core.req(1'b0, 1'b0, 7'h00, 8'h00, core_regs_pkg::ALU_NONE, 8'h00, 8'h00, e, en);
    st[4:3] = x;
    check(CORE_STATUS, st);
  endtask

  // flag operation; tw also writes d to status in the same cycle
  task alu(input core_regs_pkg::alu_op_e op, input logic [7:0] a, input logic [7:0] b,
    input logic tw, input logic [7:0] d);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] r;
    s = {1'b0, a} + {1'b0, b};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    if (op == core_regs_pkg::ALU_SUB) begin
      s = {1'b0, a} + {1'b0, ~b} + 9'h001;
      n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    end
    r = (op == core_regs_pkg::ALU_LOGIC) ? a : s[7:0];
    if (tw) st[7:5] = d[7:5];
    if (op == core_regs_pkg::ALU_ROT_LEFT) begin
      r = {a[6:0], st[0]};
      st[0] = a[7];
    end else if (op == core_regs_pkg::ALU_ROT_RIGHT) begin
      r = {st[0], a[7:1]};
      st[0] = a[0];
    end else begin
      st[2] = (r == 8'h00);
      if (op != core_regs_pkg::ALU_LOGIC) st[1:0] = {n[4], s[8]};
    end
    i_core.req(1'b0, tw, 7'h03, d, op, a, b, 3'h0, 1'b1);
    check(ALU_RESULT, r);
    check(CORE_STATUS, st);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    SYS_RST = 1'b1;
    seed = $urandom(2);
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    #1;
    st = 8'h18;
    check(CORE_STATUS, st);
    g = 8'($urandom);
    wr(7'h20, g);
    rd(7'h20, g);
    rd(7'h60, 8'h00);
    // bits 4:3 stay set, bank 3 and upper indirect pair selected
    wr(7'h03, 8'hE7);
    st = 8'hFF;
    check(CORE_STATUS, st);
    wr(7'h04, 8'h20);
    check(INDIRECT_POINTER, 8'h20);
    wr(7'h02, 8'h5A);
    check(PROG_COUNTER_LOW, 8'h5A);
    wr(7'h0A, 8'hA5);
    check(PROG_COUNTER_HIGH_LATCH, 8'hA5);
    wr(7'h0B, 8'h3C);
    check(IRQ_CONTROL, 8'h3C);
    rd(7'h04, 8'h20);
    rd(7'h20, 8'h00);
    rd(7'h00, 8'h00);
    // clear of status: banks zero, zero flag set, rest kept
    i_core.req(1'b0, 1'b1, 7'h03, 8'h00, core_regs_pkg::ALU_CLEAR, 8'h00, 8'h00, 3'h0, 1'b1);
    st = 8'h1F;
    check(CORE_STATUS, st);
    rd(7'h00, g);
    wr(7'h00, ~g);
    rd(7'h20, ~g);
    alu(core_regs_pkg::ALU_ADD, 8'hFF, 8'h01, 1'b0, 8'h00);
    alu(core_regs_pkg::ALU_SUB, 8'h05, 8'h05, 1'b0, 8'h00);
    alu(core_regs_pkg::ALU_SUB, 8'h00, 8'h01, 1'b0, 8'h00);
    alu(core_regs_pkg::ALU_ADD, 8'h08, 8'h08, 1'b1, 8'h07);
    alu(core_regs_pkg::ALU_ROT_LEFT, 8'h81, 8'h00, 1'b0, 8'h00);
    alu(core_regs_pkg::ALU_ROT_RIGHT, 8'h02, 8'h00, 1'b0, 8'h00);
    alu(core_regs_pkg::ALU_LOGIC, 8'h00, 8'h00, 1'b0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      alu(i[0] ? core_regs_pkg::ALU_SUB : core_regs_pkg::ALU_ADD, 8'($urandom),
        8'($urandom), 1'b0, 8'h00);
    end
    ev(3'h4, 1'b0, st[4:3]);
    ev(3'h4, 1'b1, 2'h1);
    ev(3'h1, 1'b1, 2'h2);
    ev(3'h2, 1'b1, 2'h3);
    ev(3'h6, 1'b1, 2'h1);
    repeat (4) @(posedge CLK);
    check(8'(exp_q.size()), 8'h00);
    print_verdict();
  end
endmodule
